// ===== sim/skc_keypad.sv
// Purpose: Operator keypad and serial printer on the far side of the block
// Assumes: Keys are active low with pull-ups, so a released key reads high
// Notes: The bench calls press(); the printer counts print pulses
`timescale 1ns/100ps
module skc_keypad (
  input wire logic hclk,
  input wire logic print_stb,
  input wire logic signed [23:0] print_data,
  output logic [4:0] key_n
);
  int prints = 0;
  logic signed [23:0] last_print = '0;
  initial key_n = 5'h1f;
  // ----------------------------------------
  // Operator
  // ----------------------------------------
  // Holds one key n cycles, releases it, then lets the block settle
  task automatic press(input int k, input int n);
    @(posedge hclk);
    key_n[k] <= 1'b0;
    repeat (n) @(posedge hclk);
    key_n[k] <= 1'b1;
    repeat (10) @(posedge hclk);
  endtask : press
  // ----------------------------------------
  // Printer
  // ----------------------------------------
  always @(posedge hclk) begin
    if (print_stb === 1'b1) begin
      prints <= prints + 1;
      last_print <= print_data;
    end
  end
endmodule : skc_keypad

// ===== sim/tb_scale_key_calibration_control.sv
// Purpose: Self-checking bench for the key and calibration control
// Assumes: Short message and hold counts; AHB-Lite master waits on hready
// Notes: Weighing scenarios run before calibration
`timescale 1ns/100ps
`include "skc_regs.svh"
module tb_scale_key_calibration_control;
  import skc_pkg::*;
  localparam int MSG = 20;
  localparam int KU = 0, KZ = 1, KN = 2, KT = 3, KP = 4;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, motion = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = '0;
  logic hready, hreadyout, hresp, power_on, print_stb;
  logic [4:0] key_n;
  logic signed [23:0] raw_count = '0, disp_value, print_data;
  skc_annun_s annun;
  skc_disp_e disp_code;
  logic [2:0] disp_err, disp_dp, flash_pos;
  int failures = 0, total_checks = 0;
  assign hready = hreadyout;
  always #4 hclk = ~hclk;

  skc_top #(.MSG_CYC(MSG), .HOLD_CYC(50)) u_skc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .key_n(key_n), .raw_count(raw_count),
    .motion(motion), .annun(annun), .disp_code(disp_code), .disp_value(disp_value), .disp_err(disp_err),
    .disp_dp(disp_dp), .flash_pos(flash_pos), .power_on(power_on), .print_stb(print_stb),
    .print_data(print_data));
  skc_keypad u_skc_keypad (.hclk(hclk), .print_stb(print_stb), .print_data(print_data), .key_n(key_n));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task set_in(input logic signed [23:0] r, input logic m);
    @(posedge hclk);
    raw_count <= r;
    motion <= m;
    repeat (6) @(posedge hclk);
  endtask : set_in
  task pr(input int k);
    u_skc_keypad.press(k, 4);
  endtask : pr
  task summarize;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize
  // Starts a procedure, moves the flashing digit, sets one digit, confirms
  task cal(input logic [2:0] c, input logic [31:0] p, input int k, input logic [31:0] ev);
    bus(1'b1, `SKC_OFF_CMD, {29'h0, c});
    repeat (3) @(posedge hclk);
    chk("prompt", p, disp_code);
    repeat (MSG + 4) @(posedge hclk);
    chk("entry", DSP_ENTRY, disp_code);
    chk("start", 0, disp_value);
    pr(KP);
    chk("pos", 1, flash_pos);
    pr(KT);
    chk("pos", 0, flash_pos);
    pr(k);
    chk("digit", ev, disp_value);
    pr(KN);
  endtask : cal

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    bus(1'b0, `SKC_OFF_CFG, 0);
    chk("cfg", 32'h3, rd);
    bus(1'b0, `SKC_OFF_CAP, 0);
    chk("cap", 32'h2710, rd);
    bus(1'b0, 8'h3c, 0);
    chk("unmapped", 0, rd);
    chk("resp", 0, hresp);
    chk("power", 1, power_on);
  endtask : t_regs
  task t_units;
    chk("lb", 1, annun.lb);
    pr(KU);
    chk("kg", 1, annun.kg);
    pr(KU);
    chk("lb", 1, annun.lb);
    bus(1'b1, `SKC_OFF_CFG, 32'h7);
    pr(KU);
    pr(KU);
    chk("pcs", 1, annun.pieces_indicator);
    pr(KU);
    chk("lb", 1, annun.lb);
    bus(1'b1, `SKC_OFF_CFG, 32'h3);
  endtask : t_units
  task t_zero;
    set_in(50, 1'b0);
    pr(KZ);
    chk("value", 0, disp_value);
    chk("coz", 1, annun.coz);
    chk("gross", 1, annun.gross);
    chk("stable", 1, annun.stable);
    set_in(51, 1'b1);
    chk("coz", 0, annun.coz);
    chk("stable", 0, annun.stable);
    pr(KZ);
    chk("value", 1, disp_value);
    set_in(151, 1'b0);
    pr(KZ);
    chk("value", 101, disp_value);
  endtask : t_zero
  task t_print;
    set_in(57, 1'b1);
    pr(KP);
    chk("prints", 0, u_skc_keypad.prints);
    set_in(57, 1'b0);
    pr(KP);
    chk("prints", 1, u_skc_keypad.prints);
    chk("data", 7, u_skc_keypad.last_print);
  endtask : t_print
  task t_tare;
    set_in(50, 1'b0);
    pr(KT);
    chk("tare", 0, annun.tare);
    pr(KN);
    chk("gross", 1, annun.gross);
    set_in(70, 1'b0);
    pr(KT);
    chk("net", 1, annun.net);
    chk("tare", 1, annun.tare);
    chk("value", 0, disp_value);
    set_in(75, 1'b0);
    pr(KN);
    chk("gross", 1, annun.gross);
    chk("value", 25, disp_value);
    pr(KN);
    chk("net", 1, annun.net);
    chk("value", 5, disp_value);
  endtask : t_tare
  task t_over;
    set_in(20100, 1'b0);
    chk("over", DSP_OVER, disp_code);
    pr(KP);
    chk("prints", 1, u_skc_keypad.prints);
    set_in(75, 1'b0);
    chk("weight", DSP_WEIGHT, disp_code);
  endtask : t_over
  task t_batt;
    pr(KN);
    bus(1'b1, `SKC_OFF_CFG, 32'hb);
    set_in(90, 1'b0);
    pr(KZ);
    chk("value", 0, disp_value);
    u_skc_keypad.press(KZ, 60);
    chk("power", 0, power_on);
    pr(KP);
    chk("power", 1, power_on);
    chk("prints", 1, u_skc_keypad.prints);
    bus(1'b1, `SKC_OFF_CFG, 32'h3);
  endtask : t_batt
  task t_span;
    bus(1'b1, `SKC_OFF_CFG, 32'h23);
    cal(`SKC_CMD_SPAN, DSP_SPAN_PROMPT, KU, 1);
    chk("dp", 2, disp_dp);
    chk("err", `SKC_ERR_LOW, disp_err);
    repeat (MSG + 4) @(posedge hclk);
    bus(1'b1, `SKC_OFF_CAP, 5);
    cal(`SKC_CMD_SPAN, DSP_SPAN_PROMPT, KZ, 9);
    chk("err", `SKC_ERR_CAP, disp_err);
    repeat (MSG + 4) @(posedge hclk);
    bus(1'b1, `SKC_OFF_CAP, 500);
    set_in(5, 1'b0);
    cal(`SKC_CMD_SPAN, DSP_SPAN_PROMPT, KZ, 9);
    chk("code", DSP_ERR, disp_code);
    chk("err", `SKC_ERR_RES, disp_err);
    repeat (MSG + 4) @(posedge hclk);
    set_in(20, 1'b0);
    cal(`SKC_CMD_SPAN, DSP_SPAN_PROMPT, KZ, 9);
    chk("done", DSP_SPAN_DONE, disp_code);
    repeat (MSG + 4) @(posedge hclk);
    chk("menu", DSP_WEIGHT, disp_code);
    bus(1'b0, `SKC_OFF_CALS, 0);
    chk("cals", 20, rd);
  endtask : t_span
  task t_view;
    bus(1'b1, `SKC_OFF_CMD, {29'h0, `SKC_CMD_VIEW});
    repeat (4) @(posedge hclk);
    chk("cal0", DSP_CAL0, disp_code);
    pr(KU);
    chk("cal1", DSP_CAL1, disp_code);
    chk("value", 20, disp_value);
    pr(KU);
    chk("menu", DSP_WEIGHT, disp_code);
  endtask : t_view
  task t_keyin;
    bus(1'b1, `SKC_OFF_CMD, {29'h0, `SKC_CMD_KEYS});
    repeat (MSG + 6) @(posedge hclk);
    pr(KN);
    chk("err", `SKC_ERR_ZSPAN, disp_err);
    chk("code", DSP_ERR, disp_code);
    repeat (MSG + 4) @(posedge hclk);
    chk("entry", DSP_ENTRY, disp_code);
    pr(KU);
    pr(KN);
    chk("saved", DSP_SPAN_SAVED, disp_code);
    repeat (MSG + 4) @(posedge hclk);
    bus(1'b0, `SKC_OFF_CALS, 0);
    chk("cals", 1, rd);
    cal(`SKC_CMD_KEYZ, DSP_CAL0, KU, 1);
    chk("saved", DSP_ZERO_SAVED, disp_code);
    repeat (MSG + 4) @(posedge hclk);
    chk("menu", DSP_WEIGHT, disp_code);
    bus(1'b0, `SKC_OFF_CALZ, 0);
    chk("calz", 1, rd);
  endtask : t_keyin

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    t_regs();
    t_units();
    t_zero();
    t_print();
    t_tare();
    t_over();
    t_batt();
    t_span();
    t_view();
    t_keyin();
    summarize();
  end
  initial begin
    repeat (30000) @(posedge hclk);
    failures++;
    summarize();
  end
endmodule : tb_scale_key_calibration_control

// ===== src/skc_entry.sv
// Purpose: Decimal entry with one flashing digit
// Assumes: Strobes are one-cycle pulses on hclk
// Notes: Digits wrap 9 to 0; position wraps across the digits
`timescale 1ns/100ps
`include "skc_regs.svh"
module skc_entry (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clr,
  input wire logic inc,
  input wire logic dec,
  input wire logic left,
  input wire logic right,
  output logic [2:0] pos,
  output logic [23:0] value
);
  typedef struct packed {
    logic [`SKC_DIGITS-1:0][3:0] dig;
    logic [2:0] pos;
    logic [23:0] val;
  } skc_entry_s;
  skc_entry_s q, d;
  always_comb begin
    d = q;
    if (clr) begin
      d = '0;
    end else if (inc) begin
      d.dig[q.pos] = (q.dig[q.pos] == 4'h9) ? 4'h0 : q.dig[q.pos] + 4'h1;
    end else if (dec) begin
      d.dig[q.pos] = (q.dig[q.pos] == 4'h0) ? 4'h9 : q.dig[q.pos] - 4'h1;
    end else if (left) begin
      d.pos = (q.pos == 3'(`SKC_DIGITS - 1)) ? 3'h0 : q.pos + 3'h1;
    end else if (right) begin
      d.pos = (q.pos == 3'h0) ? 3'(`SKC_DIGITS - 1) : q.pos - 3'h1;
    end
    d.val = '0;
    for (int i = `SKC_DIGITS - 1; i >= 0; i--) begin
      d.val = 24'(d.val * 24'ha) + 24'(d.dig[i]);
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign pos = q.pos;
  assign value = q.val;
endmodule : skc_entry

// ===== src/skc_pkg.sv
// Purpose: Types shared by the key and calibration control
// Assumes: Constants live in skc_regs.svh
// Notes: All state types are packed
package skc_pkg;
  typedef enum logic [1:0] {UNIT_LB, UNIT_KG, UNIT_PCS} skc_unit_e;
  typedef enum logic [3:0] {CAL_IDLE, SPAN_MSG, SPAN_ENT, SPAN_DONE, SPAN_ERR, VIEW_Z, VIEW_S,
    KZ_MSG, KZ_ENT, KZ_DONE, KS_MSG, KS_ENT, KS_DONE, KS_ERR} skc_cal_e;
  typedef enum logic [3:0] {DSP_OFF, DSP_WEIGHT, DSP_OVER, DSP_SPAN_PROMPT, DSP_ENTRY, DSP_SPAN_DONE,
    DSP_ERR, DSP_CAL0, DSP_CAL1, DSP_ZERO_SAVED, DSP_SPAN_SAVED} skc_disp_e;
  typedef struct packed {
    logic [24:0] rsvd;
    logic [2:0] dp;
    logic battery;
    logic [2:0] unit_en;
  } skc_cfg_s;
  typedef struct packed {
    logic coz;
    logic net;
    logic gross;
    logic tare;
    logic lb;
    logic kg;
    logic pieces_indicator;
    logic stable;
  } skc_annun_s;
  typedef struct packed {
    logic [7:0] rsvd;
    skc_annun_s annun;
    skc_disp_e disp;
    logic [2:0] err;
    skc_cal_e cal;
    logic power;
    logic tare_held;
    logic net;
    skc_unit_e unit;
  } skc_status_s;
  typedef struct packed {
    logic [3:0] units;
    logic [3:0] zero;
    logic [3:0] net_gross;
    logic [3:0] tare;
    logic [3:0] print;
  } skc_key_s;
endpackage : skc_pkg

// ===== src/skc_regs.svh
// Purpose: Register offsets, reset values and timing counts
// Assumes: 32-bit AHB-Lite data, one register per aligned word
// Notes: Definitions only
`ifndef SKC_REGS_SVH
`define SKC_REGS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SKC_OFF_CFG 8'h00
`define SKC_OFF_CAP 8'h04
`define SKC_OFF_ZRANGE 8'h08
`define SKC_OFF_DIV 8'h0c
`define SKC_OFF_CMD 8'h10
`define SKC_OFF_STATUS 8'h14
`define SKC_OFF_DISP 8'h18
`define SKC_OFF_TARE 8'h1c
`define SKC_OFF_CALZ 8'h20
`define SKC_OFF_CALS 8'h24
// ----------------------------------------
// Reset values and commands
// ----------------------------------------
`define SKC_CFG_RST 32'h0000_0003
`define SKC_CAP_RST 24'h00_2710
`define SKC_ZRANGE_RST 24'h00_0064
`define SKC_DIV_RST 24'h00_0001
`define SKC_CMD_SPAN 3'h1
`define SKC_CMD_VIEW 3'h2
`define SKC_CMD_KEYZ 3'h3
`define SKC_CMD_KEYS 3'h4
`define SKC_ERR_CAP 3'h0
`define SKC_ERR_LOW 3'h1
`define SKC_ERR_RES 3'h2
`define SKC_ERR_ZSPAN 3'h5
// ----------------------------------------
// Timing, 125 MHz clock
// ----------------------------------------
`define SKC_CLK_KHZ 125000
`define SKC_MSG_MS 1000
`define SKC_HOLD_MS 5000
`define SKC_PCT 7'h64
`define SKC_QDIV 26'h4
`define SKC_DIGITS 6
`endif

// ===== src/skc_sync.sv
// Purpose: Three-flop key synchroniser with agreement filter
// Assumes: Keys are asynchronous, active-low pins
// Notes: Level changes only when flops two and three agree
`timescale 1ns/100ps
module skc_sync #(
  parameter int W = 5
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] pin_n,
  output logic [W-1:0] level,
  output logic [W-1:0] press
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
    logic [W-1:0] prs;
  } skc_sync_s;
  skc_sync_s q, d;
  always_comb begin
    d = q;
    d.s1 = ~pin_n;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.lvl[i] = q.s3[i];
      end
    end
    d.prs = d.lvl & ~q.lvl;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign level = q.lvl;
  assign press = q.prs;
endmodule : skc_sync

// ===== src/skc_top.sv
// Purpose: Keypad interpreter and calibration procedures of a weighing indicator
// Assumes: raw_count and motion come from the measurement path on hclk
// Notes: Registers reached over AHB-Lite, zero wait states
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/100ps
`include "skc_regs.svh"
module skc_top #(
  parameter int unsigned MSG_CYC = `SKC_MSG_MS * `SKC_CLK_KHZ,
  parameter int unsigned HOLD_CYC = `SKC_HOLD_MS * `SKC_CLK_KHZ
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [4:0] key_n,
  input wire logic signed [23:0] raw_count,
  input wire logic motion,
  output skc_pkg::skc_annun_s annun,
  output skc_pkg::skc_disp_e disp_code,
  output logic signed [23:0] disp_value,
  output logic [2:0] disp_err,
  output logic [2:0] disp_dp,
  output logic [2:0] flash_pos,
  output logic power_on,
  output logic print_stb,
  output logic signed [23:0] print_data
);
  import skc_pkg::*;
  typedef struct packed {
    skc_cfg_s cfg;
    logic [23:0] cap;
    logic [23:0] zrange;
    logic [23:0] div;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    skc_cal_e cal;
    skc_unit_e unit;
    logic power;
    logic net;
    logic tare_held;
    logic signed [23:0] tare;
    logic signed [23:0] zoff;
    logic [23:0] cal_zero;
    logic [23:0] cal_span;
    logic [31:0] tmr;
    logic [31:0] hold;
    logic hold_done;
    logic [2:0] err;
    skc_disp_e disp;
    logic signed [23:0] dval;
    skc_annun_s an;
    logic prt;
    logic signed [23:0] pdata;
  } skc_top_s;
  skc_top_s q, d;
  logic [4:0] lvl, pr;
  logic [23:0] ent_val;
  logic signed [23:0] gross, shown, delta;
  logic ent_clr, entering, ovl, zero_act, any_key;
  // ----------------------------------------
  // Keys and numeric entry
  // ----------------------------------------
  skc_sync #(.W(5)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_n(key_n),
    .level(lvl),
    .press(pr)
  );
  assign entering = (q.cal == SPAN_ENT) || (q.cal == KZ_ENT) || (q.cal == KS_ENT);
  skc_entry u_entry (
    .hclk(hclk),
    .hresetn(hresetn),
    .clr(ent_clr),
    .inc(entering & pr[0]),
    .dec(entering & pr[1]),
    .left(entering & pr[4]),
    .right(entering & pr[3]),
    .pos(flash_pos),
    .value(ent_val)
  );
  assign any_key = |pr;
  assign gross = raw_count - q.zoff;
  assign delta = raw_count - $signed(q.cal_zero);
  assign shown = q.net ? gross - q.tare : gross;
  assign ovl = gross > $signed(q.cap);
  function automatic skc_unit_e next_unit(input skc_unit_e u, input logic [2:0] en);
    logic [1:0] c;
    next_unit = u;
    c = u;
    for (int i = 0; i < 3; i++) begin
      c = (c == 2'h2) ? 2'h0 : c + 2'h1;
      if (en[c] && next_unit == u) begin
        next_unit = skc_unit_e'(c);
      end
    end
  endfunction : next_unit
  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    d = q;
    d.prt = 1'b0;
    ent_clr = 1'b0;
    zero_act = 1'b0;
    // Bus: address phase captured, write completes in data phase
    if (q.wr_pend) begin
      unique case (q.wr_addr)
        `SKC_OFF_CFG: d.cfg = skc_cfg_s'(hwdata);
        `SKC_OFF_CAP: d.cap = hwdata[23:0];
        `SKC_OFF_ZRANGE: d.zrange = hwdata[23:0];
        `SKC_OFF_DIV: d.div = hwdata[23:0];
        `SKC_OFF_CMD: begin
          if (q.cal == CAL_IDLE && q.power) begin
            unique case (hwdata[2:0])
              `SKC_CMD_SPAN: d.cal = SPAN_MSG;
              `SKC_CMD_VIEW: d.cal = VIEW_Z;
              `SKC_CMD_KEYZ: d.cal = KZ_MSG;
              `SKC_CMD_KEYS: d.cal = KS_MSG;
              default: d.cal = q.cal;
            endcase
            d.tmr = '0;
            ent_clr = 1'b1;
          end
        end
        default: d.cfg = q.cfg;
      endcase
    end
    d.wr_pend = hsel && htrans[1] && hready && hwrite;
    d.wr_addr = haddr[7:0];
    if (hsel && htrans[1] && hready && !hwrite) begin
      unique case (haddr[7:0])
        `SKC_OFF_CFG: d.rdata = q.cfg;
        `SKC_OFF_CAP: d.rdata = {8'h00, q.cap};
        `SKC_OFF_ZRANGE: d.rdata = {8'h00, q.zrange};
        `SKC_OFF_DIV: d.rdata = {8'h00, q.div};
        `SKC_OFF_STATUS: d.rdata = {8'h00, q.an, q.disp, q.err, q.cal, q.power, q.tare_held, q.net, q.unit};
        `SKC_OFF_DISP: d.rdata = {{8{q.dval[23]}}, q.dval};
        `SKC_OFF_TARE: d.rdata = {{8{q.tare[23]}}, q.tare};
        `SKC_OFF_CALZ: d.rdata = {8'h00, q.cal_zero};
        `SKC_OFF_CALS: d.rdata = {8'h00, q.cal_span};
        default: d.rdata = 32'h0000_0000;
      endcase
    end
    // Calibration procedures
    d.tmr = (d.tmr == q.tmr) ? q.tmr + 32'h1 : d.tmr;
    unique case (q.cal)
      CAL_IDLE: d.tmr = '0;
      SPAN_MSG: d.cal = (q.tmr >= MSG_CYC) ? SPAN_ENT : q.cal;
      SPAN_ENT: begin
        if (pr[2]) begin
          d.tmr = '0;
          if (ent_val > q.cap) begin
            d.cal = SPAN_ERR;
            d.err = `SKC_ERR_CAP;
          end else if (27'(ent_val) * 27'(`SKC_PCT) < 27'(q.cap)) begin
            d.cal = SPAN_ERR;
            d.err = `SKC_ERR_LOW;
          end else if (delta < $signed(ent_val)) begin
            d.cal = SPAN_ERR;
            d.err = `SKC_ERR_RES;
          end else begin
            d.cal = SPAN_DONE;
            d.cal_span = delta;
          end
        end
      end
      VIEW_Z: d.cal = any_key ? VIEW_S : q.cal;
      VIEW_S: d.cal = any_key ? CAL_IDLE : q.cal;
      KZ_MSG: d.cal = (q.tmr >= MSG_CYC) ? KZ_ENT : q.cal;
      KZ_ENT: begin
        if (pr[2]) begin
          d.cal = KZ_DONE;
          d.cal_zero = ent_val;
          d.tmr = '0;
        end
      end
      KS_MSG: d.cal = (q.tmr >= MSG_CYC) ? KS_ENT : q.cal;
      KS_ENT: begin
        if (pr[2]) begin
          d.tmr = '0;
          if (ent_val == '0) begin
            d.cal = KS_ERR;
            d.err = `SKC_ERR_ZSPAN;
          end else begin
            d.cal = KS_DONE;
            d.cal_span = ent_val;
          end
        end
      end
      KS_ERR: begin
        if (q.tmr >= MSG_CYC) begin
          d.cal = KS_ENT;
          ent_clr = 1'b1;
        end
      end
      SPAN_DONE, SPAN_ERR, KZ_DONE, KS_DONE: d.cal = (q.tmr >= MSG_CYC) ? CAL_IDLE : q.cal;
      default: d.cal = CAL_IDLE;
    endcase
    // Weighing keys
    if (q.cal == CAL_IDLE) begin
      if (!q.power) begin
        if (pr[4] && q.cfg.battery) begin
          d.power = 1'b1;
        end
      end else begin
        if (pr[0]) begin
          d.unit = next_unit(q.unit, q.cfg.unit_en);
        end
        if (q.cfg.battery) begin
          if (lvl[1]) begin
            d.hold = q.hold + 32'h1;
            if (q.hold + 32'h1 >= HOLD_CYC && !q.hold_done) begin
              d.power = 1'b0;
              d.hold_done = 1'b1;
            end
          end else begin
            zero_act = (q.hold != '0) && !q.hold_done;
            d.hold = '0;
            d.hold_done = 1'b0;
          end
        end else begin
          zero_act = pr[1];
        end
        if (zero_act && !q.net && !motion && !ovl && (gross <= $signed(q.zrange)) &&
            (gross >= -$signed(q.zrange))) begin
          d.zoff = raw_count;
        end
        if (pr[2] && q.tare_held) begin
          d.net = !q.net;
        end
        if (pr[3] && gross > 0 && !motion && !ovl) begin
          d.tare = gross;
          d.tare_held = 1'b1;
          d.net = 1'b1;
        end
        if (pr[4] && !motion && !ovl) begin
          d.prt = 1'b1;
          d.pdata = shown;
        end
      end
    end
    if (!q.cfg.battery) begin
      d.power = 1'b1;
    end
    // Display and annunciators
    d.dval = '0;
    unique case (q.cal)
      CAL_IDLE: d.disp = !q.power ? DSP_OFF : (ovl ? DSP_OVER : DSP_WEIGHT);
      SPAN_MSG: d.disp = DSP_SPAN_PROMPT;
      KZ_MSG, VIEW_Z: d.disp = DSP_CAL0;
      KS_MSG, VIEW_S: d.disp = DSP_CAL1;
      SPAN_ENT, KZ_ENT, KS_ENT: d.disp = DSP_ENTRY;
      SPAN_DONE: d.disp = DSP_SPAN_DONE;
      KZ_DONE: d.disp = DSP_ZERO_SAVED;
      KS_DONE: d.disp = DSP_SPAN_SAVED;
      default: d.disp = DSP_ERR;
    endcase
    if (d.disp == DSP_WEIGHT) begin
      d.dval = shown;
    end else if (d.disp == DSP_ENTRY) begin
      d.dval = ent_val;
    end else if (q.cal == VIEW_Z) begin
      d.dval = q.cal_zero;
    end else if (q.cal == VIEW_S) begin
      d.dval = q.cal_span;
    end
    d.an = '0;
    if (q.power && q.cal == CAL_IDLE) begin
      d.an.coz = 26'($signed(shown < 0 ? -shown : shown)) * `SKC_QDIV <= 26'(q.div);
      d.an.net = q.net;
      d.an.gross = !q.net;
      d.an.tare = q.tare_held;
      d.an.stable = !motion;
      d.an.lb = (q.unit == UNIT_LB);
      d.an.kg = (q.unit == UNIT_KG);
      d.an.pieces_indicator = (q.unit == UNIT_PCS);
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.cfg <= skc_cfg_s'(`SKC_CFG_RST);
      q.cap <= `SKC_CAP_RST;
      q.zrange <= `SKC_ZRANGE_RST;
      q.div <= `SKC_DIV_RST;
    end else begin
      q <= d;
    end
  end
  assign hrdata = q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign annun = q.an;
  assign disp_code = q.disp;
  assign disp_value = q.dval;
  assign disp_err = q.err;
  assign disp_dp = q.cfg.dp;
  assign power_on = q.power;
  assign print_stb = q.prt;
  assign print_data = q.pdata;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  print_when_still_a: assert property (print_stb |-> $past(!motion && !ovl && pr[4]))
    else $error("print sent while moving or overloaded");
  tare_capture_a: assert property ($rose(q.tare_held) |-> $past(!motion && gross > 0 && pr[3]))
    else $error("tare captured without conditions");
  net_needs_tare_a: assert property (q.net |-> q.tare_held)
    else $error("net mode without tare");
  overload_shown_a: assert property (q.cal == CAL_IDLE && q.power && ovl |=> disp_code == DSP_OVER)
    else $error("overload not shown");
  span_cap_err_a: assert property (q.cal == SPAN_ENT && pr[2] && ent_val > q.cap |=>
    q.cal == SPAN_ERR && disp_err == `SKC_ERR_CAP)
    else $error("over-capacity span accepted");
  keyin_zero_span_a: assert property (q.cal == KS_ENT && pr[2] && ent_val == '0 |=>
    q.cal == KS_ERR ##1 disp_code == DSP_ERR)
    else $error("zero span value not rejected");
  view_steps_a: assert property (q.cal == VIEW_Z && any_key |=> q.cal == VIEW_S ##1 disp_value == q.cal_span)
    else $error("view did not advance to span");
  zero_gross_only_a: assert property ($changed(q.zoff) |-> $past(!q.net && !motion && !ovl))
    else $error("zero taken in bad conditions");
  stable_lamp_a: assert property (q.cal == CAL_IDLE && q.power && !motion |=> annun.stable)
    else $error("stable lamp off while still");
  power_off_hold_a: assert property ($fell(q.power) |-> $past(lvl[1] && q.cfg.battery))
    else $error("power dropped without held zero key");
  span_done_c: cover property (q.cal == SPAN_ENT && pr[2] ##1 q.cal == SPAN_DONE);
  tare_c: cover property ($rose(q.tare_held));
  print_c: cover property (print_stb);
endmodule : skc_top
